// File: hdl/alcp_fifo.sv
// Purpose: character fifo between the reply generator and the link
// Assumes: depth is a power of two
// Notes:   read side is a registered output stage in front of the memory
module alcp_fifo #(
    parameter int WIDTH = alcp_pkg::FIFO_WIDTH,
    parameter int DEPTH = alcp_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [PW:0] count_r, count_nxt;
    logic out_valid_r, out_valid_nxt;
    logic [WIDTH-1:0] out_data_r, out_data_nxt;
    logic wr, rd;

    assign in_ready = (count_r != (PW+1)'(DEPTH));
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    always_comb begin
        wr = in_valid && in_ready;
        rd = (count_r != '0) && (!out_valid_r || out_ready);
        wr_ptr_nxt = wr ? wr_ptr_r + PW'(1) : wr_ptr_r;
        rd_ptr_nxt = rd ? rd_ptr_r + PW'(1) : rd_ptr_r;
        count_nxt = count_r;
        if (wr && !rd) begin
            count_nxt = count_r + (PW+1)'(1);
        end else if (rd && !wr) begin
            count_nxt = count_r - (PW+1)'(1);
        end
        out_valid_nxt = rd ? 1'b1 : (out_ready ? 1'b0 : out_valid_r);
        out_data_nxt = rd ? mem[rd_ptr_r] : out_data_r;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (ce) begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && wr) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

endmodule : alcp_fifo

// File: hdl/alcp_parser.sv
// Purpose: ascii line command interpreter with a small variable store
// Assumes: rx characters come from logic on the same clock
// Notes:   replies pass through an 8-character fifo to the tx port
module alcp_parser (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    localparam int LM = alcp_pkg::LINE_MAX;
    localparam int NV = alcp_pkg::NVAR;
    localparam int NC = alcp_pkg::NCMD;
    localparam int IW = alcp_pkg::IDX_W;

    alcp_pkg::alcp_state_t state_r, state_nxt;
    alcp_pkg::alcp_msg_t msg_kind_r, msg_kind_nxt;
    logic [LM-1:0][7:0] buf_r, buf_nxt;
    logic [4:0] len_r, len_nxt;
    logic cmt_r, cmt_nxt, quiet_r, quiet_nxt, ovf_r, ovf_nxt;
    logic [NV-1:0][63:0] val_r, val_nxt;
    logic [NV-1:0][3:0] vlen_r, vlen_nxt;
    logic [IW-1:0] msg_idx_r, msg_idx_nxt;
    logic [4:0] msg_pos_r, msg_pos_nxt;
    logic msg_list_r, msg_list_nxt;
    logic rx_ready_r, rx_ready_nxt;

    logic accept, push, fifo_in_ready;
    logic [7:0] cur_ch;
    logic [4:0] body_len;
    logic eq_found, sp_found, is_assign, val_ok;
    logic [4:0] eq_pos, sp_pos, val_start, val_len, tok_end;
    logic [4:0] par_start, par_end, par_len;
    logic var_hit, cmd_hit, par_hit;
    logic [IW-1:0] hit_idx, cmd_idx, par_idx, last_idx;
    logic [63:0] new_val;
    logic eval_asg, eval_cmd;

    assign rx_ready = rx_ready_r;

    function automatic logic [7:0] ch_of(input logic [63:0] w,
                                         input logic [4:0] i);
        logic [63:0] s;
        s = w << (8 * i);
        ch_of = s[63:56];
    endfunction : ch_of

    // token of buf_r at start with length tlen equals word w of wlen
    function automatic logic match_word(input logic [4:0] start,
                                        input logic [4:0] tlen,
                                        input logic [63:0] w,
                                        input logic [3:0] wlen);
        logic ok;
        ok = (tlen == {1'b0, wlen});
        for (int j = 0; j < 8; j++) begin
            if (ok && 5'(j) < tlen && buf_r[start + 5'(j)] != ch_of(w,
                5'(j))) begin
                ok = 1'b0;
            end
        end
        match_word = ok;
    endfunction : match_word

    ////////////////////////////////////////////////////////////////////
    // line analysis
    always_comb begin
        eq_found = 1'b0;
        eq_pos = '0;
        sp_found = 1'b0;
        sp_pos = '0;
        for (int i = 0; i < LM; i++) begin
            if (5'(i) < len_r && !eq_found
                && buf_r[i] == alcp_pkg::CH_EQ) begin
                eq_found = 1'b1;
                eq_pos = 5'(i);
            end
            if (5'(i) < len_r && !sp_found
                && buf_r[i] == alcp_pkg::CH_SP) begin
                sp_found = 1'b1;
                sp_pos = 5'(i);
            end
        end
        is_assign = eq_found && eq_pos != '0
            && buf_r[eq_pos - 5'h1] != alcp_pkg::CH_SP;
        val_start = eq_pos + 5'h1;
        for (int i = 0; i < LM; i++) begin
            if (5'(i) == val_start && 5'(i) < len_r
                && buf_r[i] == alcp_pkg::CH_SP) begin
                val_start = val_start + 5'h1;
            end
        end
        val_len = (val_start < len_r) ? len_r - val_start : 5'h0;
        val_ok = val_len != '0 && val_len <= {1'b0, alcp_pkg::VAL_MAX};
        new_val = '0;
        for (int j = 0; j < 8; j++) begin
            if (5'(j) < val_len) begin
                new_val[63 - 8*j -: 8] = buf_r[val_start + 5'(j)];
                if (buf_r[val_start + 5'(j)] < alcp_pkg::CH_0
                    || buf_r[val_start + 5'(j)] > alcp_pkg::CH_9) begin
                    val_ok = 1'b0;
                end
            end
        end
        tok_end = sp_found ? sp_pos : len_r;
        par_start = sp_pos + 5'h1;
        par_end = len_r;
        for (int i = 0; i < LM; i++) begin
            if (5'(i) > sp_pos && 5'(i) < len_r && par_end == len_r
                && buf_r[i] == alcp_pkg::CH_SP) begin
                par_end = 5'(i);
            end
        end
        par_len = sp_found ? par_end - par_start : 5'h0;
        var_hit = 1'b0;
        hit_idx = '0;
        for (int k = 0; k < NV; k++) begin
            if (match_word(5'h0, eq_pos, alcp_pkg::VAR_NAME[k],
                           alcp_pkg::VAR_LEN[k])) begin
                var_hit = 1'b1;
                hit_idx = IW'(k);
            end
        end
        cmd_hit = 1'b0;
        cmd_idx = '0;
        par_hit = 1'b0;
        par_idx = '0;
        for (int k = 0; k < NC; k++) begin
            if (match_word(5'h0, tok_end, alcp_pkg::CMD_NAME[k],
                           alcp_pkg::CMD_LEN[k])) begin
                cmd_hit = 1'b1;
                cmd_idx = IW'(k);
            end
            if (match_word(par_start, par_len, alcp_pkg::CMD_NAME[k],
                           alcp_pkg::CMD_LEN[k])) begin
                par_hit = 1'b1;
                par_idx = IW'(k);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply character generator
    always_comb begin
        last_idx = (msg_kind_r == alcp_pkg::MSG_VAR) ? IW'(NV - 1)
            : IW'(NC - 1);
        case (msg_kind_r)
            alcp_pkg::MSG_VAR: begin
                body_len = 5'(alcp_pkg::VAR_LEN[msg_idx_r]) + 5'h2
                    + 5'(vlen_r[msg_idx_r]);
                if (msg_pos_r < 5'(alcp_pkg::VAR_LEN[msg_idx_r])) begin
                    cur_ch = ch_of(alcp_pkg::VAR_NAME[msg_idx_r],
                                   msg_pos_r);
                end else if (msg_pos_r
                    == 5'(alcp_pkg::VAR_LEN[msg_idx_r])) begin
                    cur_ch = alcp_pkg::CH_EQ;
                end else if (msg_pos_r
                    == 5'(alcp_pkg::VAR_LEN[msg_idx_r]) + 5'h1) begin
                    cur_ch = alcp_pkg::CH_SP;
                end else begin
                    cur_ch = ch_of(val_r[msg_idx_r], msg_pos_r
                        - 5'(alcp_pkg::VAR_LEN[msg_idx_r]) - 5'h2);
                end
            end
            alcp_pkg::MSG_CMD: begin
                body_len = 5'(alcp_pkg::CMD_LEN[msg_idx_r]);
                cur_ch = ch_of(alcp_pkg::CMD_NAME[msg_idx_r], msg_pos_r);
            end
            default: begin
                body_len = 5'h1;
                cur_ch = alcp_pkg::CH_QM;
            end
        endcase
        if (msg_pos_r == body_len) begin
            cur_ch = alcp_pkg::CH_CR;
        end else if (msg_pos_r == body_len + 5'h1) begin
            cur_ch = alcp_pkg::CH_LF;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control
    always_comb begin
        state_nxt = state_r;
        buf_nxt = buf_r;
        len_nxt = len_r;
        cmt_nxt = cmt_r;
        quiet_nxt = quiet_r;
        ovf_nxt = ovf_r;
        val_nxt = val_r;
        vlen_nxt = vlen_r;
        msg_kind_nxt = msg_kind_r;
        msg_idx_nxt = msg_idx_r;
        msg_pos_nxt = msg_pos_r;
        msg_list_nxt = msg_list_r;
        accept = ce && rx_valid && rx_ready_r;
        push = 1'b0;
        eval_asg = ce && state_r == alcp_pkg::ST_EVAL && !ovf_r
            && len_r != '0 && is_assign;
        eval_cmd = ce && state_r == alcp_pkg::ST_EVAL && !ovf_r
            && len_r != '0 && !is_assign;
        case (state_r)
            alcp_pkg::ST_RX: begin
                if (accept) begin
                    if (rx_data == alcp_pkg::CH_CR) begin
                        state_nxt = alcp_pkg::ST_EVAL;
                    end else if (rx_data == alcp_pkg::CH_LF) begin
                        len_nxt = len_r;
                    end else if (cmt_r) begin
                        cmt_nxt = 1'b1;
                    end else if (rx_data == alcp_pkg::CH_APOS) begin
                        cmt_nxt = 1'b1;
                    end else if (rx_data == alcp_pkg::CH_BSL
                        && len_r == '0 && !quiet_r) begin
                        quiet_nxt = 1'b1;
                    end else if (len_r == 5'(LM)) begin
                        ovf_nxt = 1'b1;
                    end else begin
                        buf_nxt[len_r] = rx_data;
                        len_nxt = len_r + 5'h1;
                    end
                end
            end
            alcp_pkg::ST_EVAL: begin
                state_nxt = alcp_pkg::ST_RX;
                len_nxt = '0;
                cmt_nxt = 1'b0;
                quiet_nxt = 1'b0;
                ovf_nxt = 1'b0;
                msg_pos_nxt = '0;
                msg_idx_nxt = '0;
                msg_list_nxt = 1'b0;
                msg_kind_nxt = alcp_pkg::MSG_ERR;
                if (ovf_r) begin
                    state_nxt = alcp_pkg::ST_TX;
                end else if (len_r == '0) begin
                    state_nxt = alcp_pkg::ST_RX;
                end else if (is_assign) begin
                    msg_kind_nxt = alcp_pkg::MSG_VAR;
                    msg_idx_nxt = hit_idx;
                    state_nxt = alcp_pkg::ST_TX;
                    if (!var_hit) begin
                        msg_kind_nxt = alcp_pkg::MSG_ERR;
                    end else if (val_len == '0) begin
                        state_nxt = alcp_pkg::ST_TX;
                    end else if (val_ok) begin
                        val_nxt[hit_idx] = new_val;
                        vlen_nxt[hit_idx] = val_len[3:0];
                        if (quiet_r) begin
                            state_nxt = alcp_pkg::ST_RX;
                        end
                    end else begin
                        state_nxt = alcp_pkg::ST_TX;
                    end
                end else begin
                    state_nxt = alcp_pkg::ST_TX;
                    if (cmd_hit && cmd_idx == alcp_pkg::CMD_HELP) begin
                        msg_kind_nxt = alcp_pkg::MSG_CMD;
                        if (par_len == '0) begin
                            msg_list_nxt = 1'b1;
                        end else if (par_hit) begin
                            msg_idx_nxt = par_idx;
                        end else begin
                            msg_kind_nxt = alcp_pkg::MSG_ERR;
                        end
                    end else if (cmd_hit) begin
                        msg_kind_nxt = alcp_pkg::MSG_VAR;
                        msg_list_nxt = 1'b1;
                    end
                end
            end
            default: begin
                if (ce && fifo_in_ready) begin
                    push = 1'b1;
                    msg_pos_nxt = msg_pos_r + 5'h1;
                    if (msg_pos_r == body_len + 5'h1) begin
                        msg_pos_nxt = '0;
                        if (msg_list_r && msg_idx_r != last_idx) begin
                            msg_idx_nxt = msg_idx_r + IW'(1);
                        end else begin
                            state_nxt = alcp_pkg::ST_RX;
                        end
                    end
                end
            end
        endcase
        rx_ready_nxt = (state_nxt == alcp_pkg::ST_RX);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= alcp_pkg::ST_RX;
            buf_r <= '0;
            len_r <= '0;
            cmt_r <= 1'b0;
            quiet_r <= 1'b0;
            ovf_r <= 1'b0;
            val_r <= alcp_pkg::VAR_RESET;
            vlen_r <= alcp_pkg::VAR_RESET_LEN;
            msg_kind_r <= alcp_pkg::MSG_ERR;
            msg_idx_r <= '0;
            msg_pos_r <= '0;
            msg_list_r <= 1'b0;
            rx_ready_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            buf_r <= buf_nxt;
            len_r <= len_nxt;
            cmt_r <= cmt_nxt;
            quiet_r <= quiet_nxt;
            ovf_r <= ovf_nxt;
            val_r <= val_nxt;
            vlen_r <= vlen_nxt;
            msg_kind_r <= msg_kind_nxt;
            msg_idx_r <= msg_idx_nxt;
            msg_pos_r <= msg_pos_nxt;
            msg_list_r <= msg_list_nxt;
            rx_ready_r <= rx_ready_nxt;
        end
    end

    alcp_fifo #(
        .WIDTH(alcp_pkg::FIFO_WIDTH),
        .DEPTH(alcp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push),
        .in_data(cur_ch),
        .in_ready(fifo_in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_cr_ends_line: assert property (
        accept && rx_data == alcp_pkg::CH_CR
        |=> state_r == alcp_pkg::ST_EVAL)
        else $error("cr did not end the line");
    a_crlf_pair: assert property (
        push && cur_ch == alcp_pkg::CH_CR
        |=> state_r == alcp_pkg::ST_TX && cur_ch == alcp_pkg::CH_LF)
        else $error("cr not followed by lf");
    a_lf_ignored: assert property (
        accept && rx_data == alcp_pkg::CH_LF
        |=> len_r == $past(len_r) && state_r == alcp_pkg::ST_RX)
        else $error("lf was not ignored");
    a_comment_drop: assert property (
        accept && rx_data != alcp_pkg::CH_CR && rx_data != alcp_pkg::CH_LF
        && (cmt_r || rx_data == alcp_pkg::CH_APOS)
        |=> len_r == $past(len_r) && cmt_r)
        else $error("comment character stored");
    a_tx_no_wait: assert property (
        ce && state_r == alcp_pkg::ST_TX && fifo_in_ready
        |=> msg_pos_r == $past(msg_pos_r) + 5'h1 || msg_pos_r == '0)
        else $error("transmitter stalled with room");
    a_cmd_reply: assert property (
        eval_cmd |=> state_r == alcp_pkg::ST_TX && msg_kind_r
        != alcp_pkg::MSG_VAR || msg_list_r)
        else $error("command line got no reply");
    a_help_param: assert property (
        eval_cmd && cmd_hit && cmd_idx == alcp_pkg::CMD_HELP && par_hit
        |=> msg_kind_r == alcp_pkg::MSG_CMD && !msg_list_r
        && msg_idx_r == $past(par_idx))
        else $error("help parameter not passed");
    a_help_list: assert property (
        eval_cmd && cmd_hit && cmd_idx == alcp_pkg::CMD_HELP
        && par_len == '0
        |=> msg_list_r && msg_kind_r == alcp_pkg::MSG_CMD)
        else $error("bare help did not list");
    a_assign_store: assert property (
        eval_asg && var_hit && val_ok
        |=> val_r[$past(hit_idx)] == $past(new_val)
        && state_r == ($past(quiet_r) ? alcp_pkg::ST_RX
        : alcp_pkg::ST_TX))
        else $error("assignment not stored or echo wrong");
    a_quiet_silent: assert property (
        eval_asg && var_hit && val_ok && quiet_r
        |=> state_r == alcp_pkg::ST_RX)
        else $error("quiet assignment echoed");
    a_reject_echo: assert property (
        eval_asg && var_hit && val_len != '0 && !val_ok
        |=> state_r == alcp_pkg::ST_TX && $stable(val_r)
        && msg_kind_r == alcp_pkg::MSG_VAR)
        else $error("refused value not echoed");
    a_query_hold: assert property (
        eval_asg && var_hit && val_len == '0
        |=> $stable(val_r) && state_r == alcp_pkg::ST_TX)
        else $error("query changed value or no reply");
    a_dump_list: assert property (
        eval_cmd && cmd_hit && cmd_idx == alcp_pkg::CMD_DUMP
        |=> msg_list_r && msg_kind_r == alcp_pkg::MSG_VAR
        && msg_idx_r == '0)
        else $error("dump did not start at first variable");

    c_dump: cover property (eval_cmd && cmd_hit
        && cmd_idx == alcp_pkg::CMD_DUMP);
    c_quiet: cover property (eval_asg && var_hit && val_ok && quiet_r);
    c_query: cover property (eval_asg && var_hit && val_len == '0);
    c_line_out: cover property (push && cur_ch == alcp_pkg::CH_LF);

endmodule : alcp_parser

// File: hdl/alcp_pkg.sv
// Purpose: shared constants and types of the ascii line command parser
// Assumes: 8-bit characters, one clock
// Notes:   names and values are held msb-first, first character on top
package alcp_pkg;

    localparam int LINE_MAX = 24;
    localparam int POS_W = 5;
    localparam int NVAR = 2;
    localparam int NCMD = 2;
    localparam int IDX_W = 1;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 8;

    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_APOS = 8'h27;
    localparam logic [7:0] CH_BSL = 8'h5c;
    localparam logic [7:0] CH_EQ = 8'h3d;
    localparam logic [7:0] CH_QM = 8'h3f;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [3:0] VAL_MAX = 4'h8;

    // variable 0 is "CutOff", variable 1 is "Gain"
    localparam logic [NVAR-1:0][63:0] VAR_NAME =
        {64'h4761696e00000000, 64'h4375744f66660000};
    localparam logic [NVAR-1:0][3:0] VAR_LEN = {4'h4, 4'h6};
    localparam logic [NVAR-1:0][63:0] VAR_RESET =
        {64'h3000000000000000, 64'h3000000000000000};
    localparam logic [NVAR-1:0][3:0] VAR_RESET_LEN = {4'h1, 4'h1};

    // command 0 is "help", command 1 is "vardump"
    localparam logic [NCMD-1:0][63:0] CMD_NAME =
        {64'h76617264756d7000, 64'h68656c7000000000};
    localparam logic [NCMD-1:0][3:0] CMD_LEN = {4'h7, 4'h4};
    localparam logic [IDX_W-1:0] CMD_HELP = 1'h0;
    localparam logic [IDX_W-1:0] CMD_DUMP = 1'h1;

    typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_TX} alcp_state_t;
    typedef enum logic [1:0] {MSG_VAR, MSG_CMD, MSG_ERR} alcp_msg_t;

endpackage : alcp_pkg

// File: testbench/alcp_host_model.sv
// Purpose: host side of the character link, collects reply characters
// Assumes: one clock shared with the parser
// Notes:   stalls tx_ready at random while stall_en is high
module alcp_host_model (
    input wire logic clock,
    input wire logic stall_en,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] seed = 32'h1d2b;
    string got = "";
    initial tx_ready = 1'b1;
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            got = {got, string'(tx_data)};
        end
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        #1 tx_ready = !stall_en || seed[1:0] != 2'h0;
    end
endmodule : alcp_host_model

// File: testbench/test_alcp_parser.sv
// Purpose: self-checking bench of the ascii line command parser
// Assumes: replies of a line are complete once rx is ready and tx idle
// Notes:   random assignments to Gain, seeded xorshift
module test_alcp_parser;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic stall_en = 1'b0;
    logic rx_ready;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic [31:0] rng = 32'hac04;
    int n_errors = 0;
    int num_checks = 0;
    string nl = "\r\n";
    alcp_parser i_alcp_parser (.clock(clock), .rst_n(rst_n), .ce(1'b1),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    alcp_host_model i_alcp_host_model (.clock(clock), .stall_en(stall_en),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    initial begin
        forever #2.5 clock = ~clock;
    end
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    // line ends shown as text so that a mismatch prints on one line
    function automatic string vis(string s);
        string r;
        r = "";
        for (int i = 0; i < s.len(); i++) begin
            if (s[i] == 8'h0d) r = {r, "<cr>"};
            else if (s[i] == 8'h0a) r = {r, "<lf>"};
            else r = {r, string'(s[i])};
        end
        return r;
    endfunction : vis
    function automatic string echo_of(string name, string val);
        return {name, "= ", val, "\r\n"};
    endfunction : echo_of
    task automatic check(string what, string seen, string exp);
        num_checks++;
        if (seen != exp) begin
            n_errors++;
            $display("ERROR %s expected \"%s\" seen \"%s\"", what, vis(exp),
                vis(seen));
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic step();
        @(posedge clock);
        #1;
    endtask : step
    // sends one line and compares everything sent back for it
    task automatic line(string s, string exp, bit lf = 1'b1);
        string t;
        string got;
        int k;
        int base;
        t = {s, "\r"};
        if (lf) t = {t, "\n"};
        base = i_alcp_host_model.got.len();
        for (int i = 0; i < t.len(); i++) begin
            rx_valid = 1'b1;
            rx_data = t[i];
            k = 0;
            while (rx_ready !== 1'b1 && k < 600) begin
                step();
                k++;
            end
            step();
        end
        rx_valid = 1'b0;
        step();
        step();
        k = 0;
        while (k < 800 && !(i_alcp_host_model.got.len() - base >= exp.len()
               && rx_ready === 1'b1 && tx_valid === 1'b0)) begin
            step();
            k++;
        end
        got = i_alcp_host_model.got;
        got = got.substr(base, got.len() - 1);
        check(s, got, exp);
    endtask : line
    initial begin
        string v;
        string cur;
        string exp;
        int n;
        cur = "3";
        repeat (16) step();
        rst_n = 1'b1;
        step();
        line("CutOff=", {"CutOff= 0", nl});
        line("Gain=5", {"Gain= 5", nl});
        line("\\CutOff=7", "");
        line("CutOff=", {"CutOff= 7", nl}, 1'b0);
        line("\\Gain=x", {"Gain= 5", nl});
        line("Gain=3'=9 zz", {"Gain= 3", nl});
        line("help", {"help", nl, "vardump", nl});
        line("help vardump", {"vardump", nl});
        line("Gain =4", {"?", nl});
        line("", "");
        stall_en = 1'b1;
        line("vardump", {"CutOff= 7", nl, "Gain= 3", nl});
        for (int r = 0; r < 10; r++) begin
            rng = xs(rng);
            n = int'(rng[3:0]) % 9 + 1;
            v = "";
            for (int d = 0; d < n; d++) begin
                rng = xs(rng);
                v = {v, string'(8'h30 + 8'(rng[7:0] % 10))};
            end
            if (n <= 8) cur = v;
            exp = echo_of("Gain", cur);
            if (rng[8] && n <= 8) exp = "";
            if (rng[8]) v = {"\\Gain=", v};
            else v = {"Gain=", v};
            line(v, exp);
        end
        line("Gain=", {"Gain= ", cur, nl});
        line("Foo=1", {"?", nl});
        line("help zz", {"?", nl});
        line("'just a note", "");
        line("abcdefghijklmnopqrstuvwxyz", {"?", nl});
        line("CutOff= 12", echo_of("CutOff", "12"));
        // reset in mid-run brings every variable back to its reset value
        rst_n = 1'b0;
        repeat (4) step();
        rst_n = 1'b1;
        step();
        exp = {echo_of("CutOff", "0"), echo_of("Gain", "0")};
        line("vardump", exp);
        give_verdict();
    end
    initial begin
        repeat (50000) @(posedge clock);
        n_errors++;
        $display("ERROR watchdog expired");
        give_verdict();
    end
endmodule : test_alcp_parser
